// file: src/afc_pkg.sv
// Summary of operation
// - Control bits 7 and 4..3 read zero.
// - Batch takes channels from first queued entry.
// - Scan mode repeats first channel for whole batch.
// - Scan plus continuous restarts after each batch ends.
// - Combine clear: any compare trigger sets flag.
// - Combine set: all triggers needed for flag.
// - Depth zero means single channel and result.
// - Nonzero depth code gives code plus one levels.
// - Batch starts once channel queue holds depth plus one.
// - Flag sets after whole batch is stored.
// - Results read back in queued channel order.
// - Single mode keeps result when enabled compare fails.
package afc_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CHAN   = 8'h00;
    localparam logic [7:0] OFS_CTRL   = 8'h04;
    localparam logic [7:0] OFS_RESULT = 8'h08;
    localparam logic [7:0] OFS_CMP    = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;

    // Field widths and queue depth
    localparam int DEPTH_W = 3;
    localparam int CH_W    = 5;
    localparam int RES_W   = 12;
    localparam int LVL_W   = 4;
    localparam int FIFO_D  = 16;
    localparam int CNT_W   = 5;

    // Channel control fields
    localparam int CHAN_CONT_BIT = 5;
    localparam int CHAN_CMPE_BIT = 6;
    localparam int CHAN_CONVERSION_COMPLETE_FLAG_BIT = 7;
    // Fifo scan compare control fields
    localparam int CTRL_SCAN_BIT = 6;
    localparam int CTRL_COMB_BIT = 5;
    localparam int CTRL_DEP_LSB  = 0;
    // Compare register fields
    localparam int CMP_GT_BIT    = 12;
    // Status fields
    localparam int STAT_CH_LSB   = 0;
    localparam int STAT_RES_LSB  = 8;
    localparam int STAT_CONVERSION_COMPLETE_FLAG_BIT = 16;
    localparam int STAT_BUSY_BIT = 17;

    // Reset values
    localparam logic [DEPTH_W-1:0] DEPTH_RST = 3'h0;
    localparam logic [RES_W-1:0]   RES_RST   = 12'h000;
    localparam logic [CH_W-1:0]    CH_RST    = 5'h00;

    typedef enum logic {AFC_IDLE, AFC_CONV} afc_state_t;

    // Fifo level for a depth code
    function automatic logic [LVL_W-1:0] afc_level(
        input logic [DEPTH_W-1:0] code
    );
        return {1'b0, code} + 4'h1;
    endfunction : afc_level
endpackage : afc_pkg

// file: src/afc_fifo.sv
module afc_fifo #(
    parameter int W  = 12,
    parameter int D  = 16,
    parameter int AW = $clog2(D)
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          reset_i,
    input  wire logic          flush_i,
    // Fill side
    input  wire logic          in_valid_i,
    output logic               in_ready_o,
    input  wire logic [W-1:0]  in_data_i,
    // Drain side
    output logic               out_valid_o,
    input  wire logic          out_ready_i,
    output logic [W-1:0]       out_data_o,
    // Fill level
    output logic [AW:0]        count_o
);
    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } afc_fifo_t;

    afc_fifo_t s_reg;
    afc_fifo_t s_next;
    logic      push;
    logic      pop;

    assign in_ready_o  = (s_reg.cnt != (AW+1)'(D));
    assign out_valid_o = (s_reg.cnt != '0);
    assign out_data_o  = s_reg.mem[s_reg.rp];
    assign count_o     = s_reg.cnt;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    always_comb begin
        s_next = s_reg;
        if (push) begin
            s_next.mem[s_reg.wp] = in_data_i;
            s_next.wp = s_reg.wp + 1'b1;
        end
        if (pop) begin
            s_next.rp = s_reg.rp + 1'b1;
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
        // Flush wins so a new batch never sees stale words
        if (flush_i) begin
            s_next.wp  = '0;
            s_next.rp  = '0;
            s_next.cnt = '0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    a_fifo_bound: assert property (@(posedge clk_i) disable iff (reset_i)
        s_reg.cnt <= (AW+1)'(D))
        else $error("fifo count above depth");
endmodule : afc_fifo

// file: src/afc_cmp.sv
module afc_cmp #(
    parameter int W = 12
) (
    // Operands
    input  wire logic [W-1:0] result_i,
    input  wire logic [W-1:0] value_i,
    input  wire logic         greater_i,
    // Trigger
    output logic              trig_o
);
    // Greater-or-equal when selected, otherwise strictly less
    assign trig_o = greater_i ? (result_i >= value_i) : (result_i < value_i);
endmodule : afc_cmp

// file: src/afc_top.sv
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
module afc_top
    import afc_pkg::*;
#(
    parameter int RES_D = afc_pkg::FIFO_D
) (
    // Clock and reset
    input  wire logic                    clk_i,
    input  wire logic                    reset_i,
    // Wishbone slave
    input  wire logic                    wb_cyc_i,
    input  wire logic                    wb_stb_i,
    input  wire logic                    wb_we_i,
    input  wire logic [7:0]              wb_adr_i,
    input  wire logic [3:0]              wb_sel_i,
    input  wire logic [31:0]             wb_dat_i,
    output logic [31:0]                  wb_dat_o,
    output logic                         wb_ack_o,
    // Converter
    output logic                         conv_start_o,
    output logic [afc_pkg::CH_W-1:0]     conv_channel_o,
    input  wire logic                    conv_done_i,
    input  wire logic [afc_pkg::RES_W-1:0] conv_result_i,
    // Channel queue back-pressure
    output logic                         chan_ready_o
);
    import afc_pkg::*;

    typedef struct packed {
        logic                ack;
        logic [31:0]         dat;
        logic [DEPTH_W-1:0]  depth;
        logic                scan;
        logic                combine;
        logic                cont;
        logic                cmp_en;
        logic                cmp_gt;
        logic [RES_W-1:0]    cmp_val;
        logic [RES_W-1:0]    result;
        logic                conversion_complete_flag;
        afc_state_t          st;
        logic [CH_W-1:0]     ch;
        logic [LVL_W-1:0]    cnt;
        logic                any;
        logic                all;
        logic                start;
    } afc_regs_t;

    afc_regs_t           s_reg;
    afc_regs_t           s_next;
    logic                bus_req;
    logic                wr_chan;
    logic                wr_ctrl;
    logic                wr_cmp;
    logic                rd_res;
    logic                fifo_en;
    logic [LVL_W-1:0]    level;
    logic                scan_eff;
    logic                ch_push;
    logic                ch_pop;
    logic                ch_valid;
    logic [CH_W-1:0]     ch_head;
    logic [CNT_W-1:0]    ch_cnt;
    logic                ch_flush;
    logic                res_push;
    logic                res_pop;
    logic                res_ready;
    logic                res_valid;
    logic [RES_W-1:0]    res_head;
    logic [CNT_W-1:0]    res_cnt;
    logic                res_flush;
    logic                ctl_flush;
    logic                scan_flush;
    logic                room;
    logic                cmp_trig;
    logic                batch_go;
    logic                batch_end;
    logic [LVL_W-1:0]    cnt_inc;
    logic [31:0]         rd;

    assign bus_req  = wb_cyc_i & wb_stb_i & ~s_reg.ack;
    assign wr_chan  = bus_req & wb_we_i & wb_sel_i[0]
                      & (wb_adr_i == OFS_CHAN);
    assign wr_ctrl  = bus_req & wb_we_i & wb_sel_i[0]
                      & (wb_adr_i == OFS_CTRL);
    assign wr_cmp   = bus_req & wb_we_i & (wb_adr_i == OFS_CMP);
    assign rd_res   = bus_req & ~wb_we_i & (wb_adr_i == OFS_RESULT);
    assign fifo_en  = (s_reg.depth != DEPTH_RST);
    assign level    = afc_level(s_reg.depth);
    assign scan_eff = s_reg.scan & fifo_en;
    assign cnt_inc  = s_reg.cnt + 4'h1;
    assign ctl_flush = wr_ctrl
        & (wb_dat_i[CTRL_DEP_LSB +: DEPTH_W] != s_reg.depth);
    assign ch_flush  = ctl_flush | scan_flush;
    assign res_flush = ctl_flush;
    // Only start a batch that the result queue can fully absorb
    assign room = ({1'b0, res_cnt} + {2'b00, level})
                  <= (CNT_W+1)'(RES_D);
    assign ch_push = wr_chan & fifo_en;
    assign res_pop = rd_res & fifo_en & res_valid;

    afc_fifo #(
        .W (CH_W),
        .D (FIFO_D)
    ) u_chan_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .flush_i     (ch_flush),
        .in_valid_i  (ch_push),
        .in_ready_o  (chan_ready_o),
        .in_data_i   (wb_dat_i[CH_W-1:0]),
        .out_valid_o (ch_valid),
        .out_ready_i (ch_pop),
        .out_data_o  (ch_head),
        .count_o     (ch_cnt)
    );

    afc_fifo #(
        .W (RES_W),
        .D (RES_D)
    ) u_res_fifo (
        .clk_i       (clk_i),
        .reset_i     (reset_i),
        .flush_i     (res_flush),
        .in_valid_i  (res_push),
        .in_ready_o  (res_ready),
        .in_data_i   (conv_result_i),
        .out_valid_o (res_valid),
        .out_ready_i (res_pop),
        .out_data_o  (res_head),
        .count_o     (res_cnt)
    );

    afc_cmp #(
        .W (RES_W)
    ) u_cmp (
        .result_i  (conv_result_i),
        .value_i   (s_reg.cmp_val),
        .greater_i (s_reg.cmp_gt),
        .trig_o    (cmp_trig)
    );

    // Read mux
    always_comb begin
        rd = 32'h0000_0000;
        unique case (wb_adr_i)
            OFS_CHAN: begin
                rd[CH_W-1:0]     = s_reg.ch;
                rd[CHAN_CONT_BIT] = s_reg.cont;
                rd[CHAN_CMPE_BIT] = s_reg.cmp_en;
                rd[CHAN_CONVERSION_COMPLETE_FLAG_BIT] = s_reg.conversion_complete_flag;
            end
            OFS_CTRL: begin
                rd[CTRL_DEP_LSB +: DEPTH_W] = s_reg.depth;
                rd[CTRL_COMB_BIT] = s_reg.combine;
                rd[CTRL_SCAN_BIT] = s_reg.scan;
            end
            OFS_RESULT: begin
                if (fifo_en) begin
                    rd[RES_W-1:0] = res_valid ? res_head : RES_RST;
                end else begin
                    rd[RES_W-1:0] = s_reg.result;
                end
            end
            OFS_CMP: begin
                rd[RES_W-1:0]  = s_reg.cmp_val;
                rd[CMP_GT_BIT] = s_reg.cmp_gt;
            end
            OFS_STATUS: begin
                rd[STAT_CH_LSB +: CNT_W]  = ch_cnt;
                rd[STAT_RES_LSB +: CNT_W] = res_cnt;
                rd[STAT_CONVERSION_COMPLETE_FLAG_BIT] = s_reg.conversion_complete_flag;
                rd[STAT_BUSY_BIT] = (s_reg.st == AFC_CONV);
            end
            default: rd = 32'h0000_0000;
        endcase
    end

    always_comb begin
        s_next     = s_reg;
        s_next.ack = 1'b0;
        s_next.start = 1'b0;
        ch_pop     = 1'b0;
        res_push   = 1'b0;
        scan_flush = 1'b0;
        batch_go   = 1'b0;
        batch_end  = 1'b0;
        if (bus_req) begin
            s_next.ack = 1'b1;
            s_next.dat = rd;
        end
        // Clears first so a same-cycle completion still sets the flag
        if (wr_chan | rd_res) begin
            s_next.conversion_complete_flag = 1'b0;
        end
        if (wr_chan) begin
            s_next.cont   = wb_dat_i[CHAN_CONT_BIT];
            s_next.cmp_en = wb_dat_i[CHAN_CMPE_BIT];
        end
        if (wr_cmp && wb_sel_i[0]) begin
            s_next.cmp_val[7:0] = wb_dat_i[7:0];
        end
        if (wr_cmp && wb_sel_i[1]) begin
            s_next.cmp_val[RES_W-1:8] = wb_dat_i[RES_W-1:8];
            s_next.cmp_gt = wb_dat_i[CMP_GT_BIT];
        end
        unique case (s_reg.st)
            AFC_IDLE: begin
                if (fifo_en && !ctl_flush && room && ch_valid
                        && (ch_cnt >= {1'b0, level})) begin
                    batch_go     = 1'b1;
                    s_next.start = 1'b1;
                    s_next.ch    = ch_head;
                    ch_pop       = ~scan_eff;
                    s_next.cnt   = '0;
                    s_next.any   = 1'b0;
                    s_next.all   = 1'b1;
                    s_next.st    = AFC_CONV;
                end
            end
            AFC_CONV: begin
                if (conv_done_i && !fifo_en) begin
                    if (!s_reg.cmp_en || cmp_trig) begin
                        s_next.result = conv_result_i;
                        s_next.conversion_complete_flag   = 1'b1;
                    end
                    if (s_reg.cont) begin
                        s_next.start = 1'b1;
                    end else begin
                        s_next.st = AFC_IDLE;
                    end
                end else if (conv_done_i) begin
                    res_push   = res_ready;
                    s_next.any = s_reg.any | cmp_trig;
                    s_next.all = s_reg.all & cmp_trig;
                    s_next.cnt = cnt_inc;
                    if (cnt_inc == level) begin
                        batch_end = 1'b1;
                        s_next.st = AFC_IDLE;
                        if (!s_reg.cmp_en) begin
                            s_next.conversion_complete_flag = 1'b1;
                        end else if (s_reg.combine) begin
                            // A failed batch never clears a pending flag
                            s_next.conversion_complete_flag = s_next.conversion_complete_flag | s_next.all;
                        end else begin
                            s_next.conversion_complete_flag = s_next.conversion_complete_flag | s_next.any;
                        end
                        // Scan keeps its channel only while continuous
                        scan_flush = scan_eff & ~s_reg.cont;
                    end else begin
                        s_next.start = 1'b1;
                        s_next.ch    = ch_head;
                        ch_pop       = ~scan_eff;
                    end
                end
            end
        endcase
        // Single mode: a channel write (re)starts a conversion
        if (wr_chan && !fifo_en) begin
            s_next.ch    = wb_dat_i[CH_W-1:0];
            s_next.start = 1'b1;
            s_next.st    = AFC_CONV;
        end
        if (wr_ctrl) begin
            s_next.depth   = wb_dat_i[CTRL_DEP_LSB +: DEPTH_W];
            s_next.combine = wb_dat_i[CTRL_COMB_BIT];
            s_next.scan    = wb_dat_i[CTRL_SCAN_BIT];
        end
        if (ctl_flush) begin
            s_next.st = AFC_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            s_reg         <= '0;
            s_reg.depth   <= DEPTH_RST;
            s_reg.result  <= RES_RST;
            s_reg.ch      <= CH_RST;
            s_reg.st      <= AFC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    assign wb_ack_o       = s_reg.ack;
    assign wb_dat_o       = s_reg.dat;
    assign conv_start_o   = s_reg.start;
    assign conv_channel_o = s_reg.ch;

    a_ctrl_rsvd_zero: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (wb_ack_o && !wb_we_i && wb_adr_i == OFS_CTRL)
        |-> (wb_dat_o[7] == 1'b0 && wb_dat_o[4:3] == 2'b00))
        else $error("reserved control bits read nonzero");

    a_batch_needs_level: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.st == AFC_IDLE && fifo_en && ch_cnt < {1'b0, level})
        |=> !conv_start_o)
        else $error("batch started below programmed depth");

    a_scan_same_chan: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (conv_start_o && s_reg.st == AFC_CONV && scan_eff
            && $past(s_reg.st) == AFC_CONV && !$past(ctl_flush))
        |-> $stable(conv_channel_o))
        else $error("scan mode changed channel inside batch");

    a_scan_cont_restart: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (batch_end && scan_eff && s_reg.cont && res_cnt < 5'h08
            && !wb_cyc_i)
        |-> ##[1:2] conv_start_o)
        else $error("scan continuous did not restart");

    a_or_sets_conversion_complete_flag: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (batch_end && s_reg.cmp_en && !s_reg.combine
            && (s_reg.any || cmp_trig)) |=> s_reg.conversion_complete_flag)
        else $error("or combine missed a trigger");

    a_and_holds_conversion_complete_flag: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (batch_end && s_reg.cmp_en && s_reg.combine
            && !(s_reg.all && cmp_trig)) |=> !$rose(s_reg.conversion_complete_flag))
        else $error("and combine set flag early");

    a_single_no_queue: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (!fifo_en && !ctl_flush)
        |=> ($stable(ch_cnt) && $stable(res_cnt)))
        else $error("queue used with depth zero");

    a_batch_length: assert property (
        @(posedge clk_i) disable iff (reset_i)
        batch_end |-> (s_reg.cnt == level - 4'h1))
        else $error("batch length not depth plus one");

    a_conversion_complete_flag_after_batch: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ($rose(s_reg.conversion_complete_flag) && fifo_en) |-> $past(batch_end))
        else $error("flag set before batch end");

    a_cmp_keeps_result: assert property (
        @(posedge clk_i) disable iff (reset_i)
        (s_reg.st == AFC_CONV && conv_done_i && !fifo_en
            && s_reg.cmp_en && !cmp_trig) |=> $stable(s_reg.result))
        else $error("result updated on failed compare");

    a_depth_flush: assert property (
        @(posedge clk_i) disable iff (reset_i)
        ctl_flush |=> (ch_cnt == '0 && res_cnt == '0))
        else $error("queues not emptied on depth change");
endmodule : afc_top

// file: dv/tb_afc_top.sv
`define CHK(a, b) begin \
    comparisons++; \
    if ((a) !== (b)) begin \
        err_count++; \
        $display("wrong value at %0t: got %h expected %h", $time, a, b); \
    end \
end

module tb_afc_top;
    timeunit 1ns;
    timeprecision 1ps;
    import afc_pkg::*;

    logic                 clk_i;
    logic                 reset_i;
    logic                 wb_cyc_i;
    logic                 wb_stb_i;
    logic                 wb_we_i;
    logic [7:0]           wb_adr_i;
    logic [3:0]           wb_sel_i;
    logic [31:0]          wb_dat_i;
    logic [31:0]          wb_dat_o;
    logic                 wb_ack_o;
    logic                 conv_start_o;
    logic [CH_W-1:0]      conv_channel_o;
    logic                 conv_done_i;
    logic [RES_W-1:0]     conv_result_i;
    logic                 chan_ready_o;
    int                   err_count;
    int                   comparisons;
    int                   cycles;
    logic [CH_W-1:0]      st_q[$];
    logic [31:0]          v;

    afc_top i_dut (
        .clk_i          (clk_i),
        .reset_i        (reset_i),
        .wb_cyc_i       (wb_cyc_i),
        .wb_stb_i       (wb_stb_i),
        .wb_we_i        (wb_we_i),
        .wb_adr_i       (wb_adr_i),
        .wb_sel_i       (wb_sel_i),
        .wb_dat_i       (wb_dat_i),
        .wb_dat_o       (wb_dat_o),
        .wb_ack_o       (wb_ack_o),
        .conv_start_o   (conv_start_o),
        .conv_channel_o (conv_channel_o),
        .conv_done_i    (conv_done_i),
        .conv_result_i  (conv_result_i),
        .chan_ready_o   (chan_ready_o)
    );

    // One bus clock also paces the converter stand-in
    always #4 clk_i = ~clk_i;

    // Starts are logged so a pulse during a bus cycle is never missed
    always @(posedge clk_i) begin
        if (conv_start_o === 1'b1) begin
            st_q.push_back(conv_channel_o);
        end
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            final_report();
        end
    end

    task automatic wb_xfer(input logic we, input logic [7:0] adr,
                           input logic [31:0] dat, output logic [31:0] rd);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= 4'hf;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        // No limit here: only the bench timeout ends a stalled access
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask : wb_xfer

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb_xfer(1'b1, adr, dat, d);
    endtask : wr

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] d;
        wb_xfer(1'b0, adr, 32'h0, d);
        `CHK(d, exp)
    endtask : rd_chk

    // Converter stand-in answers a few cycles after each start
    task automatic conv(input logic [CH_W-1:0] ch,
                        input logic [RES_W-1:0] res);
        int n;
        logic [CH_W-1:0] got;
        n = 0;
        while (st_q.size() == 0 && n < 200) begin
            @(posedge clk_i);
            n++;
        end
        if (st_q.size() == 0) begin
            err_count++;
        end else begin
            got = st_q.pop_front();
            `CHK(got, ch)
        end
        repeat (2) @(posedge clk_i);
        conv_done_i   <= 1'b1;
        conv_result_i <= res;
        @(posedge clk_i);
        conv_done_i   <= 1'b0;
        conv_result_i <= ~res;
        @(posedge clk_i);
    endtask : conv

    initial begin
        clk_i = 0; reset_i = 1; wb_cyc_i = 0; wb_stb_i = 0; wb_we_i = 0;
        wb_adr_i = 8'h00; wb_sel_i = 4'hf; wb_dat_i = 32'h0;
        conv_done_i = 0; conv_result_i = 12'h000;
        err_count = 0; comparisons = 0; cycles = 0;
        repeat (2) @(posedge clk_i);
        reset_i <= 1'b0;
        @(posedge clk_i);
        `CHK(chan_ready_o, 1'b1)
        rd_chk(OFS_CTRL, 32'h0);
        rd_chk(OFS_STATUS, 32'h0);
        rd_chk(8'h14, 32'h0);
        wr(OFS_CTRL, 32'hff);
        rd_chk(OFS_CTRL, 32'h67);
        // Scan bit with depth zero: one plain conversion only
        wr(OFS_CTRL, 32'h40);
        wr(OFS_CHAN, 32'h03);
        conv(5'h03, 12'habc);
        repeat (4) @(posedge clk_i);
        `CHK(st_q.size(), 0)
        rd_chk(OFS_CHAN, 32'h83);
        rd_chk(OFS_RESULT, 32'habc);
        // Every nonzero depth code: start held until the queue holds depth plus one channels
        for (int c = 1; c < 8; c++) begin
            wr(OFS_CTRL, 32'(c));
            for (int i = 0; i < c; i++) wr(OFS_CHAN, 32'(i + c));
            repeat (4) @(posedge clk_i);
            `CHK(st_q.size(), 0)
            wr(OFS_CHAN, 32'(2 * c));
            for (int i = 0; i <= c; i++) conv(5'(i + c), 12'(c * 16 + i));
            rd_chk(OFS_STATUS, 32'h10000 | 32'((c + 1) << 8));
            for (int i = 0; i <= c; i++) rd_chk(OFS_RESULT, 32'(c * 16 + i));
        end
        // OR then AND of compare triggers, one hit and one miss
        wr(OFS_CMP, 32'h1800);
        for (int m = 0; m < 2; m++) begin
            wr(OFS_CTRL, 32'h01 | 32'(m << 5));
            wr(OFS_CHAN, 32'h41);
            wr(OFS_CHAN, 32'h42);
            conv(5'h01, 12'h900);
            conv(5'h02, 12'h100);
            rd_chk(OFS_STATUS, m == 0 ? 32'h10200 : 32'h00200);
            rd_chk(OFS_RESULT, 32'h900);
            rd_chk(OFS_RESULT, 32'h100);
        end
        // Scan with continuous: same channel, batch after batch
        wr(OFS_CTRL, 32'h41);
        wr(OFS_CHAN, 32'h29);
        wr(OFS_CHAN, 32'h24);
        for (int i = 0; i < 4; i++) conv(5'h09, 12'(i));
        // New depth empties both queues and aborts the batch
        wr(OFS_CTRL, 32'h03);
        st_q.delete();
        wr(OFS_CHAN, 32'h01);
        wr(OFS_CHAN, 32'h02);
        wb_xfer(1'b0, OFS_STATUS, 32'h0, v);
        `CHK(v[12:0], 13'h0002)
        wr(OFS_CTRL, 32'h02);
        wb_xfer(1'b0, OFS_STATUS, 32'h0, v);
        `CHK(v[12:0], 13'h0000)
        // Fill the channel queue until it refuses, converter stalled
        wr(OFS_CTRL, 32'h07);
        for (int i = 0; i < 20 && chan_ready_o === 1'b1; i++) begin
            wr(OFS_CHAN, 32'(i));
        end
        `CHK(chan_ready_o, 1'b0)
        for (int i = 0; i < 8; i++) conv(5'(i), 12'(i + 32));
        for (int i = 0; i < 8; i++) rd_chk(OFS_RESULT, 32'(i + 32));
        wr(OFS_CTRL, 32'h00);
        `CHK(chan_ready_o, 1'b1)
        // Single mode compare, less-than direction, then continuous
        st_q.delete();
        wr(OFS_CMP, 32'h0800);
        wr(OFS_CHAN, 32'h45);
        conv(5'h05, 12'h900);
        rd_chk(OFS_CHAN, 32'h45);
        rd_chk(OFS_RESULT, 32'habc);
        wr(OFS_CHAN, 32'h66);
        conv(5'h06, 12'h100);
        conv(5'h06, 12'h200);
        rd_chk(OFS_RESULT, 32'h200);
        final_report();
    end
endmodule : tb_afc_top
